/* rtl/spi_buffer_command_engine.sv */
// serial-host command engine for the input and output staging buffers
`include "spi_engine_map.svh"
module spi_buffer_command_engine
   import spi_engine_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
)
(
   input wire logic clk_i, // 200 MHz device clock
   input wire logic reset_i, // synchronous reset, active high
   input wire logic cs_n_i, // chip select from host, active low
   input wire logic sck_i, // serial clock from host, idle low
   input wire logic sdi_i, // serial data from host
   output logic sdo_o, // serial data to host
   output logic sdo_oe_o, // serial output driven
   input wire logic [7:0] status0_i, // status byte 0
   input wire logic [7:0] status1_i, // status byte 1
   input wire logic [7:0] status2_i, // status byte 2
   output logic wr_valid_o, // staging write pending
   input wire logic wr_ready_i, // staging memory takes write
   output logic [`ADDR_W-1:0] wr_addr_o, // staging write byte address
   output logic [31:0] wr_data_o, // staging write word
   output logic wr_overrun_o, // write word lost, buffer full
   output logic rd_req_o, // staging read request
   output logic [`ADDR_W-1:0] rd_addr_o, // staging read byte address
   input wire logic [31:0] rd_data_i, // read word, one cycle after request
   output logic [`PTR_W-1:0] input_stage_pointer_o, // input staging pointer
   output logic [`PTR_W-1:0] output_stage_pointer_o, // output staging pointer
   output logic [31:0] input_command_mask_o, // input command mask
   output logic [31:0] input_command_request_o, // input command request
   output logic request_write_o // request register written
);
   engine_state_t st_q;
   engine_state_t st_d;
   stage_write_t fifo_out;
   logic push_ready;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic byte_done;
   logic commit;
   logic [7:0] rx_byte;
   logic [`COUNT_W-1:0] frame_len;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         r = (r[15] ^ b[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic parity_ok(input logic [7:0] b);
      return ~(^b[7:1]);
   endfunction

   function automatic cmd_info_t decode(input logic [7:0] b);
      cmd_info_t c;
      c = '{kind: K_XFER, wr_en: 1'b0, wr_cont: 1'b0, rd_en: 1'b0, rd_cont: 1'b0};
      if (!parity_ok(b))
      begin
         c.kind = K_NOP;
      end
      else
      begin
         case (b)
            `OP_READ_INIT: c.rd_en = 1'b1;
            `OP_READ_CONT: {c.rd_en, c.rd_cont} = 2'b11;
            `OP_COMBO_II: {c.wr_en, c.rd_en} = 2'b11;
            `OP_COMBO_CI: {c.wr_en, c.rd_en, c.rd_cont} = 3'b111;
            `OP_COMBO_IC: {c.wr_en, c.wr_cont, c.rd_en} = 3'b111;
            `OP_COMBO_CC: {c.wr_en, c.wr_cont, c.rd_en, c.rd_cont} = 4'hf;
            `OP_WRITE_INIT: c.wr_en = 1'b1;
            `OP_WRITE_CONT: {c.wr_en, c.wr_cont} = 2'b11;
            `OP_SET_IN_PTR: c.kind = K_SET_IN;
            `OP_SET_OUT_PTR: c.kind = K_SET_OUT;
            `OP_IN_CMD_WRITE: c.kind = K_IN_CMD;
            default: c.kind = K_NOP;
         endcase
      end
      return c;
   endfunction

   assign cs_fall = st_q.cs_s[2] & ~st_q.cs_s[1];
   assign cs_rise = ~st_q.cs_s[2] & st_q.cs_s[1];
   assign sck_rise = ~st_q.sck_s[2] & st_q.sck_s[1];
   assign sck_fall = st_q.sck_s[2] & ~st_q.sck_s[1];
   assign rx_byte = {st_q.rx_sh[6:0], st_q.sdi_s[1]};
   assign byte_done = (st_q.phase == PH_FRAME) && sck_rise && (st_q.bit_cnt == 3'd7);
   assign frame_len = st_q.last + `ACK_TAIL;
   // any extra clock edge after the acknowledge moves the counters off the frame end
   assign commit = cs_rise && (st_q.phase == PH_FRAME) && (st_q.byte_cnt == frame_len) &&
      (st_q.bit_cnt == 3'd0) && st_q.ack_ok;

   always_comb
   begin
      logic [`COUNT_W-1:0] k;
      logic [`COUNT_W-1:0] j;
      logic [`COUNT_W-1:0] span;
      logic [1:0] lane;
      logic [5:0] w;
      logic [`ADDR_W-1:0] base;
      logic [7:0] nb;
      k = st_q.byte_cnt;
      j = k + 1'b1;
      span = '0;
      lane = '0;
      w = '0;
      base = '0;
      nb = 8'h00;
      st_d = st_q;
      st_d.cs_s = {st_q.cs_s[1:0], cs_n_i};
      st_d.sck_s = {st_q.sck_s[1:0], sck_i};
      st_d.sdi_s = {st_q.sdi_s[0], sdi_i};
      st_d.req_pulse = 1'b0;
      st_d.rd_req = 1'b0;
      st_d.rd_pend = st_q.rd_req;
      st_d.overrun = 1'b0;
      if (st_q.rd_pend)
      begin
         st_d.rd_word = rd_data_i;
      end
      if (st_q.wr_push && push_ready)
      begin
         st_d.wr_push = 1'b0;
      end
      if (cs_fall)
      begin
         st_d.phase = PH_FRAME;
         st_d.bit_cnt = '0;
         st_d.byte_cnt = '0;
         st_d.tx = status0_i;
         st_d.crc_tx = crc_byte(`CRC_SEED, status0_i);
         st_d.crc_rx = `CRC_SEED;
         st_d.ack_ok = 1'b0;
         st_d.info = '{kind: K_NOP, wr_en: 1'b0, wr_cont: 1'b0, rd_en: 1'b0, rd_cont: 1'b0};
         st_d.last = `LAST_CRC_SHORT;
      end
      else if (st_q.phase == PH_FRAME && cs_rise)
      begin
         st_d.phase = PH_IDLE;
         if (commit)
         begin
            unique case (st_q.info.kind)
               K_NOP:
               begin
               end
               K_XFER:
               begin
                  if (st_q.info.wr_en)
                  begin
                     st_d.in_ptr = st_q.in_ptr + 1'b1;
                  end
                  if (st_q.info.rd_en)
                  begin
                     st_d.out_ptr = st_q.out_ptr + 1'b1;
                  end
               end
               K_SET_IN: st_d.in_ptr = st_q.hdr;
               K_SET_OUT: st_d.out_ptr = st_q.hdr;
               K_IN_CMD:
               begin
                  st_d.request = st_q.pend;
                  st_d.req_pulse = 1'b1;
               end
            endcase
         end
      end
      else if (st_q.phase == PH_FRAME)
      begin
         if (sck_fall)
         begin
            st_d.tx = (st_q.bit_cnt == 3'd0) ? st_q.nxt : {st_q.tx[6:0], 1'b0};
         end
         if (sck_rise)
         begin
            st_d.rx_sh = rx_byte;
            st_d.bit_cnt = st_q.bit_cnt + 1'b1;
         end
         if (byte_done)
         begin
            if (k != {`COUNT_W{1'b1}})
            begin
               st_d.byte_cnt = j;
            end
            if (k == '0)
            begin
               st_d.info = decode(rx_byte);
               st_d.last = (st_d.info.kind == K_IN_CMD) ? `LAST_CRC_IN_CMD : `LAST_CRC_SHORT;
               if (st_d.info.wr_en && !st_d.info.wr_cont)
               begin
                  st_d.in_ptr = '0;
               end
               if (st_d.info.rd_en && !st_d.info.rd_cont)
               begin
                  st_d.out_ptr = '0;
               end
            end
            if (k == 9'd1)
            begin
               st_d.hdr = rx_byte;
               if (st_q.info.kind == K_XFER)
               begin
                  span = {1'b0, (rx_byte & `WORD_COUNT_MASK)} + 9'd1;
                  st_d.last = `LAST_CRC_SHORT + (span << 2);
               end
            end
            if (j < st_d.last)
            begin
               st_d.crc_rx = crc_byte(st_q.crc_rx, rx_byte);
            end
            else if (j == st_d.last)
            begin
               st_d.crc_hi = rx_byte;
            end
            else if (k == st_d.last)
            begin
               st_d.ack_ok = (st_q.crc_rx == {st_q.crc_hi, rx_byte});
            end
            // incoming words go to the staging memory as they complete
            if (st_q.info.kind == K_XFER && st_q.info.wr_en && k >= 9'd2 && j < st_d.last)
            begin
               lane = k[1:0] - 2'd2;
               w = 6'((k - 9'd2) >> 2);
               st_d.wr_item.data[8*lane +: 8] = rx_byte;
               if (lane == 2'd3)
               begin
                  base = `IN_STAGE_BASE + (st_q.info.wr_cont ? {2'b00, st_q.in_ptr, 2'b00} : '0);
                  st_d.wr_item.addr = base + {4'h0, w, 2'b00};
                  st_d.overrun = st_q.wr_push && !push_ready;
                  st_d.wr_push = 1'b1;
               end
            end
            if (st_q.info.kind == K_IN_CMD && k >= 9'd1 && k <= 9'd8)
            begin
               lane = 2'(k - 9'd1);
               if (k <= 9'd4)
               begin
                  st_d.mask[8*lane +: 8] = rx_byte;
               end
               else
               begin
                  st_d.pend[8*lane +: 8] = rx_byte;
               end
            end
            // fetch each read word one byte ahead of its first output byte
            if (st_d.info.kind == K_XFER && st_d.info.rd_en && k >= 9'd1 && (k[1:0] == 2'd1) &&
               (k + 9'd2 < st_d.last))
            begin
               w = 6'((k - 9'd1) >> 2);
               base = `OUT_STAGE_BASE + (st_d.info.rd_cont ? {2'b00, st_d.out_ptr, 2'b00} : '0);
               st_d.rd_addr = base + {4'h0, w, 2'b00};
               st_d.rd_req = 1'b1;
            end
            if (j == 9'd1)
            begin
               nb = status1_i;
            end
            else if (j == 9'd2)
            begin
               nb = status2_i;
            end
            else if (st_d.info.rd_en && j >= `STATUS_BYTES && j < st_d.last)
            begin
               lane = j[1:0] + 2'd1;
               nb = st_q.rd_word[8*lane +: 8];
            end
            else if (j == st_d.last)
            begin
               nb = st_q.crc_tx[15:8];
            end
            else if (j == st_d.last + 9'd1)
            begin
               nb = st_q.crc_tx[7:0];
            end
            else if (j == st_d.last + 9'd2)
            begin
               nb = st_d.ack_ok ? `ACK_PASS : `ACK_FAIL;
            end
            st_d.nxt = nb;
            if (j < st_d.last)
            begin
               st_d.crc_tx = crc_byte(st_q.crc_tx, nb);
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   stage_fifo #(
      .WIDTH($bits(stage_write_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_write_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(st_q.wr_push),
      .in_ready_o(push_ready),
      .in_data_i(st_q.wr_item),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(fifo_out)
   );

   assign sdo_o = st_q.tx[7];
   assign sdo_oe_o = (st_q.phase == PH_FRAME);
   assign wr_addr_o = fifo_out.addr;
   assign wr_data_o = fifo_out.data;
   assign wr_overrun_o = st_q.overrun;
   assign rd_req_o = st_q.rd_req;
   assign rd_addr_o = st_q.rd_addr;
   assign input_stage_pointer_o = st_q.in_ptr;
   assign output_stage_pointer_o = st_q.out_ptr;
   assign input_command_mask_o = st_q.mask;
   assign input_command_request_o = st_q.request;
   assign request_write_o = st_q.req_pulse;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_commit_xfer_wr;
      commit && st_q.info.kind == K_XFER && st_q.info.wr_en;
   endsequence
   sequence s_frame_start;
      cs_fall ##1 (st_q.phase == PH_FRAME);
   endsequence

   property p_commit_in_step;
      s_commit_xfer_wr |=> input_stage_pointer_o == $past(input_stage_pointer_o) + 8'h01;
   endproperty
   a_commit_in_step: assert property (p_commit_in_step) else $error("input pointer did not step");

   property p_no_commit_stable;
      (cs_rise && !commit) |=> $stable(input_stage_pointer_o) && $stable(output_stage_pointer_o);
   endproperty
   a_no_commit_stable: assert property (p_no_commit_stable) else $error("pointer moved without commit");

   property p_abort_blocks;
      (cs_rise && st_q.phase == PH_FRAME && st_q.byte_cnt > frame_len) |-> !commit;
   endproperty
   a_abort_blocks: assert property (p_abort_blocks) else $error("abort byte did not cancel commit");

   property p_set_in_load;
      (commit && st_q.info.kind == K_SET_IN) |=> input_stage_pointer_o == $past(st_q.hdr);
   endproperty
   a_set_in_load: assert property (p_set_in_load) else $error("input pointer not loaded");

   property p_set_out_load;
      (commit && st_q.info.kind == K_SET_OUT) |=> output_stage_pointer_o == $past(st_q.hdr);
   endproperty
   a_set_out_load: assert property (p_set_out_load) else $error("output pointer not loaded");

   property p_request_only_commit;
      !(commit && st_q.info.kind == K_IN_CMD) |=> $stable(input_command_request_o) && !request_write_o;
   endproperty
   a_request_only_commit: assert property (p_request_only_commit) else $error("request written outside commit");

   property p_mask_on_arrival;
      (byte_done && st_q.info.kind == K_IN_CMD && st_q.byte_cnt == 9'd1) |=> input_command_mask_o[7:0] == $past(rx_byte);
   endproperty
   a_mask_on_arrival: assert property (p_mask_on_arrival) else $error("mask byte not stored");

   property p_ack_value;
      (byte_done && st_q.byte_cnt + 9'd1 == st_q.last + 9'd2) |=> st_q.nxt == (st_q.ack_ok ? 8'hff : 8'h00);
   endproperty
   a_ack_value: assert property (p_ack_value) else $error("acknowledge byte wrong");

   property p_status0_first;
      s_frame_start |-> sdo_oe_o && st_q.tx == $past(status0_i);
   endproperty
   a_status0_first: assert property (p_status0_first) else $error("status byte 0 not first");

   property p_parity_nop;
      (byte_done && st_q.byte_cnt == 9'd0 && ^rx_byte[7:1]) |=> st_q.info.kind == K_NOP;
   endproperty
   a_parity_nop: assert property (p_parity_nop) else $error("bad parity not turned into no-op");

   property p_init_read_clear;
      (byte_done && st_q.byte_cnt == 9'd0 && rx_byte == 8'h42) |=> output_stage_pointer_o == 8'h00;
   endproperty
   a_init_read_clear: assert property (p_init_read_clear) else $error("output pointer not cleared");
endmodule

/* rtl/spi_engine_map.svh */
// constants of the serial staging-buffer command engine
// Notes on behaviour
// - 42H clears output pointer, reads from 0600H.
// - 60H reads from 0600H plus four times pointer.
// - 50H clears both pointers, uses both bases.
// - 72H clears input pointer, continues reading.
// - 5AH continues writing, clears output pointer.
// - 78H continues both writing and reading.
// - acknowledge is FFH on good CRC, else 00H.
// - passing frame advances used pointers by one.
// - no chip-select rise, no pointer step or load; opcode clears act at once.
// - abort byte suppresses commit despite edges.
// - word count byte is words minus one.
// - transfer frame is six plus four per word.
// - 82H loads input pointer on good commit.
// - input pointer used only by continued writes.
// - 88H loads output pointer on good commit.
// - output pointer used only by continued reads.
// - pointer-write frames are six bytes long.
// - 90H mask bytes stored as they arrive.
// - 90H request word stored only on commit.
// - input command frame is thirteen bytes long.
// - CRC-16, polynomial 1021H, seed 1D0FH, MSB first.
// - parity error or unknown opcode means no-op.
// - first three output bytes are status bytes.
`ifndef SPI_ENGINE_MAP_SVH
`define SPI_ENGINE_MAP_SVH
`define OP_READ_INIT       8'h42
`define OP_READ_CONT       8'h60
`define OP_COMBO_II        8'h50
`define OP_COMBO_CI        8'h72
`define OP_COMBO_IC        8'h5a
`define OP_COMBO_CC        8'h78
`define OP_WRITE_INIT      8'h12
`define OP_WRITE_CONT      8'h18
`define OP_SET_IN_PTR      8'h82
`define OP_SET_OUT_PTR     8'h88
`define OP_IN_CMD_WRITE    8'h90
`define IN_STAGE_BASE      12'h400
`define OUT_STAGE_BASE     12'h600
`define ACK_PASS           8'hff
`define ACK_FAIL           8'h00
`define CRC_POLY           16'h1021
`define CRC_SEED           16'h1d0f
`define STATUS_BYTES       9'h003
`define LAST_CRC_SHORT     9'h003
`define LAST_CRC_IN_CMD    9'h00a
`define ACK_TAIL           9'h003
`define WORD_COUNT_MASK    8'h3f
`define ADDR_W             12
`define COUNT_W            9
`define PTR_W              8
`endif

/* rtl/spi_engine_pkg.sv */
// types of the serial staging-buffer command engine
package spi_engine_pkg;
`include "spi_engine_map.svh"
   typedef enum logic [2:0] {K_NOP, K_XFER, K_SET_IN, K_SET_OUT, K_IN_CMD} cmd_kind_t;
   typedef enum logic {PH_IDLE, PH_FRAME} phase_t;
   typedef struct packed {
      cmd_kind_t kind;
      logic wr_en;
      logic wr_cont;
      logic rd_en;
      logic rd_cont;
   } cmd_info_t;
   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [31:0] data;
   } stage_write_t;
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] sck_s;
      logic [1:0] sdi_s;
      phase_t phase;
      logic [2:0] bit_cnt;
      logic [`COUNT_W-1:0] byte_cnt;
      logic [`COUNT_W-1:0] last;
      logic [7:0] rx_sh;
      logic [7:0] tx;
      logic [7:0] nxt;
      logic [15:0] crc_rx;
      logic [15:0] crc_tx;
      logic [7:0] crc_hi;
      logic ack_ok;
      cmd_info_t info;
      logic [7:0] hdr;
      logic [`PTR_W-1:0] in_ptr;
      logic [`PTR_W-1:0] out_ptr;
      logic [31:0] mask;
      logic [31:0] pend;
      logic [31:0] request;
      logic req_pulse;
      logic rd_req;
      logic rd_pend;
      logic [`ADDR_W-1:0] rd_addr;
      logic [31:0] rd_word;
      logic wr_push;
      stage_write_t wr_item;
      logic overrun;
   } engine_state_t;
endpackage

/* rtl/stage_fifo.sv */
// small first-in first-out buffer in the staging write path
module stage_fifo
   import spi_engine_pkg::*;
#(
   parameter int WIDTH = 44,
   parameter int DEPTH = 2
)
(
   input wire logic clk_i, // clock
   input wire logic reset_i, // synchronous reset
   input wire logic in_valid_i, // source has a word
   output logic in_ready_o, // buffer has room
   input wire logic [WIDTH-1:0] in_data_i, // incoming word
   output logic out_valid_o, // buffer holds a word
   input wire logic out_ready_i, // sink takes the word
   output logic [WIDTH-1:0] out_data_o // oldest word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready_o = (cnt_q != DEPTH_C);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_data_i;
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

/* tb/spi_buffer_command_engine_tb.sv */
// self-checking bench of the staging-buffer command engine
module spi_buffer_command_engine_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import spi_engine_pkg::*;
   logic clk_i = 0, reset_i = 1, wr_ready_i = 0, stall = 0;
   logic cs_n, sck, sdi, sdo, sdo_oe, wr_valid, overrun, rd_req, req_wr;
   logic [7:0] status_q [3];
   logic [11:0] wr_addr, rd_addr;
   logic [31:0] wr_data, mask, request, rd_data_i = 0;
   logic [7:0] iptr, optr, mi = 0, mo = 0;
   logic [31:0] mmask = 0, mreq = 0;
   logic [43:0] got[$], expq[$];
   logic [7:0] ops [12] = '{8'h42, 8'h60, 8'h50, 8'h72, 8'h5a, 8'h78, 8'h82, 8'h88, 8'h90, 8'h40, 8'h12, 8'h18};
   integer seed = 32'hca9aac55;
   int err_count = 0, samples_checked = 0, overruns = 0, pulses = 0, mpulse = 0, oe_cycles = 0;
   always #2.5 clk_i = ~clk_i;
   spi_host_model host_u (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo));
   spi_buffer_command_engine dut_u (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
      .sdo_o(sdo), .sdo_oe_o(sdo_oe), .status0_i(status_q[0]), .status1_i(status_q[1]), .status2_i(status_q[2]),
      .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .wr_overrun_o(overrun), .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data_i),
      .input_stage_pointer_o(iptr), .output_stage_pointer_o(optr), .input_command_mask_o(mask),
      .input_command_request_o(request), .request_write_o(req_wr));
   // staging memory: reads answer one cycle on, otherwise the bus carries noise
   always @(posedge clk_i)
   begin
      rd_data_i <= rd_req ? {4'h0, rd_addr, 4'h0, rd_addr} : $random(seed);
      wr_ready_i <= !stall && ($random(seed) & 1);
      if (wr_valid && wr_ready_i) got.push_back({wr_addr, wr_data});
      if (overrun) overruns++;
      if (req_wr) pulses++;
      if (sdo_oe) oe_cycles++;
   end
   function automatic logic [15:0] crc16(input logic [7:0] b [272], input int last);
      logic [15:0] c = 16'h1d0f;
      for (int i = 0; i <= last; i++)
         for (int j = 7; j >= 0; j--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // mode 0 clean, 1 corrupted check word, 2 extra abort byte
   task automatic frame(input logic [7:0] op, input int n, input int mode);
      int e, oe0;
      logic xfer, wen, ren;
      logic [11:0] wb, rb;
      logic [31:0] w;
      xfer = op inside {8'h12, 8'h18, 8'h42, 8'h60, 8'h50, 8'h72, 8'h5a, 8'h78};
      wen = op inside {8'h12, 8'h18, 8'h50, 8'h72, 8'h5a, 8'h78};
      ren = xfer && !(op inside {8'h12, 8'h18});
      e = xfer ? 7 + 4 * n : (op == 8'h90 ? 10 : 3);
      for (int k = 0; k < 272; k++) host_u.tx[k] = 8'($random(seed));
      host_u.tx[0] = op;
      if (xfer) host_u.tx[1] = 8'(n);
      {host_u.tx[e - 1], host_u.tx[e]} = crc16(host_u.tx, e - 2) ^ (mode == 1 ? 16'h0100 : 16'h0000);
      @(posedge clk_i);
      for (int k = 0; k < 3; k++) status_q[k] <= 8'($random(seed));
      if (op inside {8'h42, 8'h50, 8'h5a}) mo = 0;
      if (op inside {8'h12, 8'h50, 8'h72}) mi = 0;
      wb = 12'h400 + 12'(4 * mi);
      rb = 12'h600 + 12'(4 * mo);
      if (wen)
         for (int k = 0; k <= n; k++)
            expq.push_back({wb + 12'(4 * k), host_u.tx[5 + 4 * k], host_u.tx[4 + 4 * k], host_u.tx[3 + 4 * k],
               host_u.tx[2 + 4 * k]});
      #1.3;
      oe0 = oe_cycles;
      host_u.run(e + 3 + (mode == 2));
      for (int k = 0; k < 3; k++) chk(host_u.rx[k], status_q[k], "status");
      if (ren)
         for (int k = 0; k < 4 * (n + 1); k++)
         begin
            w = {4'h0, rb + 12'(4 * (k / 4)), 4'h0, rb + 12'(4 * (k / 4))};
            chk(host_u.rx[3 + k], w[8 * (k % 4) +: 8], "read data");
         end
      chk({host_u.rx[e], host_u.rx[e + 1]}, crc16(host_u.rx, e - 1), "return check");
      chk(host_u.rx[e + 2], mode == 1 ? 8'h00 : 8'hff, "ack");
      if (op == 8'h90) mmask = {host_u.tx[4], host_u.tx[3], host_u.tx[2], host_u.tx[1]};
      if (mode == 0)
      begin
         if (wen) mi++;
         if (ren) mo++;
         if (op == 8'h90) mpulse++;
         if (op == 8'h82) mi = host_u.tx[1];
         if (op == 8'h88) mo = host_u.tx[1];
         if (op == 8'h90) mreq = {host_u.tx[8], host_u.tx[7], host_u.tx[6], host_u.tx[5]};
      end
      for (int k = 0; k < 200 && (wr_valid !== 1'b0 || got.size() < expq.size()); k++) @(posedge clk_i);
      chk(iptr, mi, "input pointer");
      chk(optr, mo, "output pointer");
      chk(mask, mmask, "mask");
      chk(request, mreq, "request");
      chk(pulses, mpulse, "request pulse");
      chk(oe_cycles > oe0 && sdo_oe === 1'b0, 1, "output enable");
      if (stall) chk(overruns > 0, 1, "overrun");
      else
      begin
         chk(got.size(), expq.size(), "write count");
         for (int k = 0; k < got.size() && k < expq.size(); k++) chk(got[k], expq[k], "write");
      end
      got.delete();
      expq.delete();
   endtask
   initial
   begin
      #450000;
      err_count++;
      complete_run();
   end
   initial
   begin
      for (int k = 0; k < 3; k++) status_q[k] = 8'h00;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      for (int k = 0; k < 12; k++) frame(ops[k], k % 4, 0);
      frame(8'h82, 0, 2);
      frame(8'h88, 0, 1);
      frame(8'h90, 0, 2);
      frame(8'h78, 1, 2);
      frame(8'h50, 63, 0);
      stall = 1'b1;
      frame(8'h5a, 3, 0);
      stall = 1'b0;
      // let the stalled words drain so the next frame starts with an empty write path
      repeat (40) @(posedge clk_i);
      got.delete();
      repeat (30) frame(ops[($random(seed) & 32'h7fff) % 12], $random(seed) & 3, ($random(seed) & 3) % 3);
      complete_run();
   end
endmodule

/* tb/spi_host_model.sv */
// host-side serial master model that clocks whole command frames
module spi_host_model (
   output logic cs_n_o, // chip select, active low
   output logic sck_o, // serial clock, idle low
   output logic sdi_o, // data to device
   input wire logic sdo_i // data from device
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx [272];
   logic [7:0] rx [272];
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // clock stands still outside frames; the data line is inverted just before chip select rises
   task automatic run(input int len);
      cs_n_o = 1'b0;
      #40;
      for (int i = 0; i < len; i++)
         for (int b = 7; b >= 0; b--)
         begin
            sdi_o = tx[i][b];
            #24;
            rx[i][b] = sdo_i;
            sck_o = 1'b1;
            #24;
            sck_o = 1'b0;
         end
      #30;
      sdi_o = ~sdi_o;
      cs_n_o = 1'b1;
      #100;
   endtask
endmodule
